//--- hw/rmc_pkg.sv
package rmc_pkg;
  // Four-level pin codes
  typedef enum logic [1:0] {LVL0, LVL1, LVL2, LVL3} rmc_lvl_e;
  // Control modes
  typedef enum logic [1:0] {MODE_STRAP, MODE_EEPROM, MODE_SLAVE, MODE_TEST} rmc_mode_e;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STRAPS = 8'h08;
  localparam logic [7:0] OFS_BOOST = 8'h0c;
  localparam logic [7:0] OFS_GAIN = 8'h10;
  localparam logic [7:0] OFS_EE_DATA = 8'h14;
  // Reset values
  localparam logic [31:0] RST_BOOST = 32'h0000_0000;
  localparam logic [31:0] RST_GAIN = 32'h0000_0000;
  // Base of the slave address; low 4 bits come from the straps
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h18;
  // EEPROM load timing
  localparam int LOAD_WORDS = 4;
  localparam int LOAD_TIME_NS = 200;
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOAD_CYCLES = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_CNT_W = 8;
  // Edges after reset release before the pin stages hold real pin levels
  localparam int SYNC_STAGES = 2;
endpackage : rmc_pkg

//--- hw/rmc_sync_if.sv
// Synchronised pin levels handed from the pin stage to the core
interface rmc_sync_if;
  logic [1:0] mode_lvl;
  logic [1:0] strap_a_lo;
  logic [1:0] strap_b_lo;
  logic [1:0] strap_a_hi;
  logic [1:0] strap_b_hi;
  logic [1:0] flat_lo;
  logic [1:0] flat_hi;
  logic pd_lo;
  logic pd_hi;
  logic load_start_n;
  modport src (output mode_lvl, strap_a_lo, strap_b_lo, strap_a_hi, strap_b_hi,
    flat_lo, flat_hi, pd_lo, pd_hi, load_start_n);
  modport dst (input mode_lvl, strap_a_lo, strap_b_lo, strap_a_hi, strap_b_hi,
    flat_lo, flat_hi, pd_lo, pd_hi, load_start_n);
endinterface : rmc_sync_if

//--- hw/rmc_pin_sync.sv
// Two-flop synchroniser for every pin level
module rmc_pin_sync
  import rmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [19:0] pins,
  rmc_sync_if.src sy
);
  typedef struct packed {
    logic [19:0] s1;
    logic [19:0] s2;
  } rmc_sync_s;
  rmc_sync_s st_r, st_nxt;

  // Shift pins through two stages
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
  end

  // State register; pull-down defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only the second stage is visible
  assign sy.mode_lvl = st_r.s2[1:0];
  assign sy.strap_a_lo = st_r.s2[3:2];
  assign sy.strap_b_lo = st_r.s2[5:4];
  assign sy.strap_a_hi = st_r.s2[7:6];
  assign sy.strap_b_hi = st_r.s2[9:8];
  assign sy.flat_lo = st_r.s2[11:10];
  assign sy.flat_hi = st_r.s2[13:12];
  assign sy.pd_lo = st_r.s2[14];
  assign sy.pd_hi = st_r.s2[15];
  assign sy.load_start_n = st_r.s2[16];
endmodule : rmc_pin_sync

//--- hw/rmc_ctrl.sv
// How it works
// - Mode level zero takes all configuration from straps, serial bus unused.
// - Mode level one loads configuration from external EEPROM as bus master.
// - Successful EEPROM load drives load-complete open-drain output low.
// - EEPROM mode also answers as bus slave before, during, after load.
// - Mode level two is bus slave only; external master sets configuration.
// - Mode level three is reserved test mode, no user configuration path.
// - Mode changes are honoured at power-up and during operation.
// - Slave address straps sampled once at power-up set slave address.
// - Strap mode samples boost straps once; strap A low sets channels 0-3, strap B high sets 4-7.
// - Strap mode samples flat-gain straps once; one per channel half.
// - Lower power-down high powers down channels 0-3, low runs them.
// - Upper power-down high powers down channels 4-7, low runs them.
// - Power-down inputs act in every mode, never overridden by mode.
// - EEPROM mode starts load when active-low load-start is seen low.
// - High-speed path stays disabled for the whole EEPROM load.
// - Slave and strap modes ignore the load-start input entirely.
// - EEPROM mode releases load-complete while load failed or incomplete.
// - Slave and strap modes keep load-complete in high impedance.
module rmc_ctrl
  import rmc_pkg::*;
#(
  parameter int LOAD_WORDS_P = LOAD_WORDS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode_pin,
  input wire logic [1:0] boost_strap_a_lo_slave_addr_a,
  input wire logic [1:0] boost_strap_b_lo_slave_addr_b,
  input wire logic [1:0] boost_strap_a_hi,
  input wire logic [1:0] boost_strap_b_hi,
  input wire logic [1:0] flat_level_strap_lo,
  input wire logic [1:0] flat_level_strap_hi,
  input wire logic powerdown_lower_half,
  input wire logic powerdown_upper_half,
  input wire logic load_start_n,
  input wire logic eeprom_word_valid,
  input wire logic [31:0] eeprom_word,
  input wire logic eeprom_error,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic load_done_n_o,
  output logic load_done_n_oe_n,
  output logic eeprom_fetch_req,
  output logic serial_master_en,
  output logic serial_slave_en,
  output logic [6:0] slave_addr,
  output logic [7:0] lane_enable,
  output logic [15:0] linear_boost_equalizer,
  output logic [15:0] flat_gain
);
  typedef enum logic [1:0] {LD_IDLE, LD_RUN, LD_DONE, LD_FAIL} rmc_ld_e;
  typedef struct packed {
    logic sampled;
    logic [1:0] warm;
    logic [1:0] addr_a;
    logic [1:0] addr_b;
    logic [7:0] strap_boost;
    logic [3:0] strap_flat;
    rmc_mode_e mode;
    rmc_ld_e ld;
    logic [LOAD_CNT_W-1:0] cnt;
    logic [31:0] boost_reg;
    logic [31:0] gain_reg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic done_o;
    logic done_oe_n;
    logic fetch;
    logic m_en;
    logic s_en;
    logic [6:0] saddr;
    logic [7:0] lanes;
    logic [15:0] boost_o;
    logic [15:0] flat_o;
  } rmc_ctrl_s;
  rmc_ctrl_s st_r, st_nxt;

  rmc_sync_if sy ();
  logic [31:0] rd_val;
  logic rd_ok;
  logic apb_acc;

  // Every pin passes two flops first
  rmc_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({3'h0, load_start_n, powerdown_upper_half, powerdown_lower_half,
      flat_level_strap_hi, flat_level_strap_lo, boost_strap_b_hi, boost_strap_a_hi,
      boost_strap_b_lo_slave_addr_b, boost_strap_a_lo_slave_addr_a, mode_pin}),
    .sy(sy)
  );

  assign apb_acc = psel && penable && !st_r.pready;

  // Register read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      OFS_CTRL: rd_val = {30'h0, st_r.mode};
      OFS_STATUS: rd_val = {28'h0, st_r.ld, sy.pd_hi, sy.pd_lo};
      OFS_STRAPS: rd_val = {13'h0, st_r.saddr, st_r.strap_flat, st_r.strap_boost};
      OFS_BOOST: rd_val = st_r.boost_reg;
      OFS_GAIN: rd_val = st_r.gain_reg;
      OFS_EE_DATA: rd_val = {24'h0, LOAD_WORDS_P[7:0]};
      default: rd_ok = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Capture straps once, after the pin stages have filled from reset
    if (!st_r.sampled) begin
      if (st_r.warm != 2'(SYNC_STAGES)) begin
        st_nxt.warm = st_r.warm + 2'h1;
      end else begin
        st_nxt.sampled = 1'b1;
        st_nxt.addr_a = sy.strap_a_lo;
        st_nxt.addr_b = sy.strap_b_lo;
        st_nxt.strap_boost = {sy.strap_b_hi, sy.strap_a_hi, sy.strap_b_lo, sy.strap_a_lo};
        st_nxt.strap_flat = {sy.flat_hi, sy.flat_lo};
      end
    end
    st_nxt.saddr = {SLAVE_ADDR_BASE[6:4], st_r.addr_b, st_r.addr_a};
    // Mode follows the pin at all times
    st_nxt.mode = rmc_mode_e'(sy.mode_lvl);
    if (st_r.mode != rmc_mode_e'(sy.mode_lvl)) begin
      st_nxt.ld = LD_IDLE;
    end else if (st_r.mode == MODE_EEPROM) begin
      case (st_r.ld)
        LD_IDLE: begin
          if (!sy.load_start_n && st_r.sampled) begin
            st_nxt.ld = LD_RUN;
            st_nxt.cnt = '0;
          end
        end
        LD_RUN: begin
          if (eeprom_error) begin
            st_nxt.ld = LD_FAIL;
          end else if (eeprom_word_valid) begin
            if (st_r.cnt[1:0] == 2'h0) st_nxt.boost_reg = eeprom_word;
            if (st_r.cnt[1:0] == 2'h1) st_nxt.gain_reg = eeprom_word;
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.cnt == LOAD_CNT_W'(LOAD_WORDS_P - 1)) st_nxt.ld = LD_DONE;
          end
        end
        LD_DONE: st_nxt.ld = LD_DONE;
        LD_FAIL: st_nxt.ld = LD_FAIL;
        default: st_nxt.ld = LD_IDLE;
      endcase
    end else begin
      st_nxt.ld = LD_IDLE;
    end
    // Bus slave; live in EEPROM and slave modes
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (apb_acc) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !rd_ok || !st_r.s_en;
      if (!pwrite) st_nxt.prdata = (rd_ok && st_r.s_en) ? rd_val : 32'h0000_0000;
      if (pwrite && st_r.s_en && paddr == OFS_BOOST) st_nxt.boost_reg = pwdata;
      if (pwrite && st_r.s_en && paddr == OFS_GAIN) st_nxt.gain_reg = pwdata;
    end
    st_nxt.s_en = (st_r.mode == MODE_EEPROM) || (st_r.mode == MODE_SLAVE);
    st_nxt.m_en = (st_r.mode == MODE_EEPROM) && (st_r.ld == LD_RUN);
    st_nxt.fetch = (st_r.mode == MODE_EEPROM) && (st_r.ld == LD_RUN);
    // Load-complete open drain
    st_nxt.done_oe_n = 1'b1;
    st_nxt.done_o = 1'b0;
    if (st_r.mode == MODE_EEPROM && st_r.ld == LD_DONE) begin
      st_nxt.done_oe_n = 1'b0;
    end // released otherwise
    // Configuration source
    case (st_r.mode)
      MODE_STRAP: begin
        st_nxt.boost_o = {st_r.strap_boost[7:6], st_r.strap_boost[7:6], st_r.strap_boost[7:6],
          st_r.strap_boost[7:6], st_r.strap_boost[1:0], st_r.strap_boost[1:0],
          st_r.strap_boost[1:0], st_r.strap_boost[1:0]};
        st_nxt.flat_o = {{4{st_r.strap_flat[3:2]}}, {4{st_r.strap_flat[1:0]}}};
      end
      MODE_EEPROM, MODE_SLAVE: begin
        st_nxt.boost_o = st_r.boost_reg[15:0];
        st_nxt.flat_o = st_r.gain_reg[15:0];
      end
      default: begin
        st_nxt.boost_o = '0;
        st_nxt.flat_o = '0;
      end
    endcase
    // Lanes: power-down in every mode, load blanks path
    st_nxt.lanes = {{4{!sy.pd_hi}}, {4{!sy.pd_lo}}};
    if (st_r.mode == MODE_EEPROM && st_r.ld == LD_RUN) begin
      st_nxt.lanes = 8'h00;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{mode: MODE_STRAP, ld: LD_IDLE, boost_reg: RST_BOOST, gain_reg: RST_GAIN,
        done_oe_n: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign load_done_n_o = st_r.done_o;
  assign load_done_n_oe_n = st_r.done_oe_n;
  assign eeprom_fetch_req = st_r.fetch;
  assign serial_master_en = st_r.m_en;
  assign serial_slave_en = st_r.s_en;
  assign slave_addr = st_r.saddr;
  assign lane_enable = st_r.lanes;
  assign linear_boost_equalizer = st_r.boost_o;
  assign flat_gain = st_r.flat_o;

  // Checks
  property p_done_only_eeprom;
    @(posedge pclk) disable iff (!presetn)
      (st_r.mode != MODE_EEPROM) |=> load_done_n_oe_n;
  endproperty
  a_done_only_eeprom: assert property (p_done_only_eeprom) else $error("done low out of mode");
  property p_done_after_load;
    @(posedge pclk) disable iff (!presetn)
      (st_r.ld == LD_DONE && st_r.mode == MODE_EEPROM) |=> !load_done_n_oe_n;
  endproperty
  a_done_after_load: assert property (p_done_after_load) else $error("done not driven");
  property p_released;
    @(posedge pclk) disable iff (!presetn)
      (st_r.ld == LD_RUN) |=> load_done_n_oe_n;
  endproperty
  a_released: assert property (p_released) else $error("done driven early");
  property p_path_off;
    @(posedge pclk) disable iff (!presetn)
      (st_r.ld == LD_RUN && st_r.mode == MODE_EEPROM) |=> lane_enable == 8'h00;
  endproperty
  a_path_off: assert property (p_path_off) else $error("path on during load");
  property p_pd_lo;
    @(posedge pclk) disable iff (!presetn)
      (sy.pd_lo && st_r.ld != LD_RUN) |=> lane_enable[3:0] == 4'h0;
  endproperty
  a_pd_lo: assert property (p_pd_lo) else $error("lower half not down");
  property p_pd_hi;
    @(posedge pclk) disable iff (!presetn)
      (sy.pd_hi && st_r.ld != LD_RUN) |=> lane_enable[7:4] == 4'h0;
  endproperty
  a_pd_hi: assert property (p_pd_hi) else $error("upper half not down");
  property p_no_reload;
    @(posedge pclk) disable iff (!presetn)
      (st_r.ld == LD_DONE && $stable(st_r.mode)) |=> st_r.ld == LD_DONE || st_r.ld == LD_IDLE;
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("repeated load");
  property p_ignore_start;
    @(posedge pclk) disable iff (!presetn)
      (st_r.mode != MODE_EEPROM) |=> st_r.ld != LD_RUN;
  endproperty
  a_ignore_start: assert property (p_ignore_start) else $error("load outside mode");
  property p_mode_follow;
    @(posedge pclk) disable iff (!presetn)
      $changed(sy.mode_lvl) |=> st_r.mode == rmc_mode_e'($past(sy.mode_lvl));
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("mode not followed");
  property p_strap_hold;
    @(posedge pclk) disable iff (!presetn) st_r.sampled |=> $stable(st_r.strap_boost);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap code moved");
  // Bus slave: access phase, then one ready cycle
  sequence s_bus_access;
    psel && penable && !pready;
  endsequence
  property p_bus_answer;
    @(posedge pclk) disable iff (!presetn) s_bus_access |=> pready;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus access not answered");
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_bus_refuse;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !serial_slave_en) |=> pslverr;
  endproperty
  a_bus_refuse: assert property (p_bus_refuse) else $error("bus access not refused");
  // Load start seen in EEPROM mode
  property p_load_start;
    @(posedge pclk) disable iff (!presetn)
      (st_r.mode == MODE_EEPROM && sy.mode_lvl == 2'h1 && st_r.ld == LD_IDLE &&
        st_r.sampled && !sy.load_start_n) |=> st_r.ld == LD_RUN;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load not started");
endmodule : rmc_ctrl

//--- sim/rmc_ee_model.sv
// Serial EEPROM reader stand-in: serves configuration words on request
module rmc_ee_model
  import rmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_req,
  input wire logic fail,
  output logic word_valid,
  output logic [31:0] word,
  output logic error
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx;
  int gap;
  // One word every few cycles; idle data line toggles so it never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 0;
      gap <= 2;
      word_valid <= 1'b0;
      word <= 32'h0;
      error <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      word <= ~word;
      if (!fetch_req) begin
        idx <= 0;
        gap <= 2;
        error <= 1'b0;
      end else if (fail) begin
        error <= 1'b1;
      end else if (gap != 0) begin
        gap <= gap - 1;
      end else if (idx < LOAD_WORDS) begin
        word_valid <= 1'b1;
        word <= 32'h0000_1e2d + idx;
        idx <= idx + 1;
        gap <= 3;
      end
    end
  end
endmodule // rmc_ee_model

//--- sim/tb_top.sv
module tb_top
  import rmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [1:0] mode_pin = 2'h0;
  logic [1:0] sa_lo = 2'h2;
  logic [1:0] sb_lo = 2'h1;
  logic [1:0] fl_lo = 2'h1;
  logic [1:0] fl_hi = 2'h2;
  logic pd_lo = 1'b0;
  logic pd_hi = 1'b0;
  logic load_start_n = 1'b1;
  logic fail = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic ee_valid, ee_error, pready, pslverr, load_done_n_o, load_done_n_oe_n;
  logic eeprom_fetch_req, serial_master_en, serial_slave_en;
  logic [31:0] ee_word, prdata;
  logic [6:0] slave_addr;
  logic [7:0] lane_enable;
  logic [15:0] linear_boost_equalizer, flat_gain;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  rmc_ctrl DUT (.pclk(pclk), .presetn(presetn), .mode_pin(mode_pin),
    .boost_strap_a_lo_slave_addr_a(sa_lo), .boost_strap_b_lo_slave_addr_b(sb_lo),
    .boost_strap_a_hi(2'h3), .boost_strap_b_hi(2'h0),
    .flat_level_strap_lo(fl_lo), .flat_level_strap_hi(fl_hi),
    .powerdown_lower_half(pd_lo), .powerdown_upper_half(pd_hi),
    .load_start_n(load_start_n), .eeprom_word_valid(ee_valid), .eeprom_word(ee_word),
    .eeprom_error(ee_error), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .load_done_n_o(load_done_n_o),
    .load_done_n_oe_n(load_done_n_oe_n), .eeprom_fetch_req(eeprom_fetch_req),
    .serial_master_en(serial_master_en), .serial_slave_en(serial_slave_en),
    .slave_addr(slave_addr), .lane_enable(lane_enable),
    .linear_boost_equalizer(linear_boost_equalizer), .flat_gain(flat_gain));

  rmc_ee_model ee (.pclk(pclk), .presetn(presetn), .fetch_req(eeprom_fetch_req),
    .fail(fail), .word_valid(ee_valid), .word(ee_word), .error(ee_error));

  // Clock and hang guard
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, then lets one idle edge pass
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee_exp);
    logic [31:0] d;
    logic er;
    apb(1'b0, a, 32'h0, d, er);
    chk(d, e);
    chk(er, ee_exp);
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic ee_exp);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk(er, ee_exp);
  endtask

  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  task automatic lanes_chk();
    logic [7:0] e;
    e = ~{{4{pd_hi}}, {4{pd_lo}}};
    chk(lane_enable, e);
  endtask

  // Main sequence
  initial begin
    int m;
    int p;
    int i;
    logic rep;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(load_done_n_oe_n, 1'b1);
    chk(slave_addr, {SLAVE_ADDR_BASE[6:4], 2'h1, 2'h2});
    chk(flat_gain, 16'haa55);
    chk(linear_boost_equalizer, 16'h00aa);
    sa_lo <= 2'h0;
    fl_lo <= 2'h3;
    settle();
    chk(slave_addr, {SLAVE_ADDR_BASE[6:4], 2'h1, 2'h2});
    chk(flat_gain, 16'haa55);
    chk(linear_boost_equalizer, 16'h00aa);
    wrc(OFS_BOOST, 32'h0000_ffff, 1'b1);
    rdc(OFS_EE_DATA, 32'h0, 1'b1);
    load_start_n <= 1'b0;
    settle();
    chk(eeprom_fetch_req, 1'b0);
    chk(load_done_n_oe_n, 1'b1);
    load_start_n <= 1'b1;
    // Power-down halves in each usable mode
    for (m = 0; m < 3; m++) begin
      mode_pin <= m[1:0];
      for (p = 0; p < 4; p++) begin
        {pd_hi, pd_lo} <= p[1:0];
        settle();
        lanes_chk();
      end
      chk(serial_slave_en, m != 0);
    end
    {pd_hi, pd_lo} <= 2'h0;
    wrc(OFS_BOOST, 32'h0000_c3a5, 1'b0);
    rdc(OFS_BOOST, 32'h0000_c3a5, 1'b0);
    chk(linear_boost_equalizer, 16'hc3a5);
    load_start_n <= 1'b0;
    settle();
    chk(eeprom_fetch_req, 1'b0);
    chk(load_done_n_oe_n, 1'b1);
    load_start_n <= 1'b1;
    mode_pin <= 2'h3;
    settle();
    rdc(OFS_EE_DATA, 32'h0, 1'b1);
    chk(serial_slave_en, 1'b0);
    chk(linear_boost_equalizer, 16'h0000);
    // EEPROM load that succeeds
    mode_pin <= 2'h1;
    settle();
    chk(load_done_n_oe_n, 1'b1);
    load_start_n <= 1'b0;
    for (i = 0; i < 20 && eeprom_fetch_req !== 1'b1; i++) @(posedge pclk);
    chk(eeprom_fetch_req, 1'b1);
    chk(serial_master_en, 1'b1);
    chk(lane_enable, 8'h00);
    rdc(OFS_EE_DATA, LOAD_WORDS, 1'b0);
    chk(load_done_n_oe_n, 1'b1);
    for (i = 0; i < 100 && load_done_n_oe_n !== 1'b0; i++) @(posedge pclk);
    chk(load_done_n_oe_n, 1'b0);
    chk(linear_boost_equalizer, 16'h1e2d);
    chk(flat_gain, 16'h1e2e);
    settle();
    lanes_chk();
    // Start held low after completion must not reload
    rep = 1'b0;
    repeat (50) begin
      @(posedge pclk);
      rep = rep | eeprom_fetch_req;
    end
    chk(rep, 1'b0);
    load_start_n <= 1'b1;
    mode_pin <= 2'h0;
    settle();
    chk(load_done_n_oe_n, 1'b1);
    // EEPROM load that fails keeps the pin released
    fail <= 1'b1;
    mode_pin <= 2'h1;
    settle();
    chk(eeprom_fetch_req, 1'b0);
    load_start_n <= 1'b0;
    for (i = 0; i < 20 && eeprom_fetch_req !== 1'b1; i++) @(posedge pclk);
    chk(eeprom_fetch_req, 1'b1);
    repeat (30) @(posedge pclk);
    chk(load_done_n_oe_n, 1'b1);
    conclude();
  end
endmodule // tb_top
